// file: rtl/trigger_output_unit.v
// Summary of operation
// - The unit raises a notification when its sequence completes or fails.
// - The configured waveform appears on the chosen pin from the programmed start time.
// - Changing the pin while high drops the old pin and raises the new one.
// - Four 16-bit target registers hold seconds and nanoseconds; output starts on match.
// - Waveform code 010 gives one low-going pulse.
// - Waveform code 011 gives one high-going pulse.
// - Pulse width or periodic high time is a 16-bit count of 8 ns steps.
// - Bits 3 to 0 of the mode register choose the driven pin.
// - Notification needs both the notify bit and the unit interrupt enable bit.
// - The unit acts only once its bit in the shared enable register is set.
// - Single mode drives the inactive level as soon as the unit is enabled.
// - Cascade mode drives the inactive level 8 ns before the target time.
// - The start-now bit starts output at once without waiting for the target.
// - Waveform code 101 gives a positive periodic signal with programmed high time.
// - Cycle or bit width is a 32-bit value in 1 ns units from two registers.
// - A zero cycle count makes periodic output run until stopped.
// - A nonzero cycle count limits periodic output to exactly that many cycles.
// - Waveform code 110 shifts out the 16-bit pattern register.
// - Each pattern bit lasts the programmed width; the pattern shifts N times.
// - Timing is quantised to 8 ns; for one unit only, an edge select bit trims duty variation.
// - Shared status registers report done, error and active, one bit per unit.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "trigger_unit_map.vh"

module trigger_output_unit #(
	parameter UNIT_INDEX = 0,
	parameter EDGE_SEL_UNIT = 1
) (
	input wire pclk,
	input wire presetn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [31:0] ptp_sec,
	input wire [31:0] ptp_ns,
	output reg [11:0] gpio_out,
	output reg [11:0] gpio_oe,
	output reg notify_irq
);
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_WAIT = 4'b0010;
	localparam [3:0] S_RUN = 4'b0100;
	localparam [3:0] S_HALT = 4'b1000;

	reg [3:0] state_reg;
	reg [15:0] tgt_ns_low_reg, tgt_ns_high_reg, tgt_sec_low_reg, tgt_sec_high_reg;
	reg [15:0] mode_pin_config_reg, pulse_width_reg, cycle_width_a_reg, cycle_width_b_reg;
	reg [15:0] cycle_count_reg, shift_pattern_reg, edge_select_reg;
	reg unit_enable_reg, irq_enable_reg, done_reg, error_reg;
	reg enable_seen_reg, level_reg, drive_reg;
	reg [15:0] hi_cnt_reg, cyc_cnt_reg, shifter_reg;
	reg access_reg, state_next_halt;
	reg [31:0] rdata_next;
	reg unmapped_next;
	reg [11:0] out_next, oe_next;
	wire [63:0] now, target, lead_now;
	wire [2:0] mode;
	wire [3:0] pin;
	wire active_high, single_shot, periodic, cascade, start_now;
	wire wr, sw_reset, enable_rise, reached, lead_reached, past;
	wire tick;
	wire finite_end;
	wire [31:0] cycle_width;
	wire [15:0] unit_bit;

	// Word index match for the decoder.
	function idx_hit;
		input [11:0] addr;
		input [9:0] idx;
		begin
			idx_hit = (addr[11:2] == idx);
		end
	endfunction

	// Active level of the waveform: high for positive modes and the pattern.
	function level_active;
		input [2:0] m;
		begin
			level_active = (m == `MODE_POS_EDGE) || (m == `MODE_POS_PULSE) ||
				(m == `MODE_POS_PERIOD) || (m == `MODE_PATTERN);
		end
	endfunction

	assign unit_bit = 16'h0001 << UNIT_INDEX;
	assign mode = mode_pin_config_reg[`CFG_MODE_MSB:`CFG_MODE_LSB];
	assign pin = mode_pin_config_reg[`CFG_PIN_MSB:`CFG_PIN_LSB];
	assign cascade = mode_pin_config_reg[`CFG_CASCADE_BIT];
	assign start_now = mode_pin_config_reg[`CFG_START_NOW_BIT];
	assign active_high = level_active(mode);
	assign single_shot = (mode == `MODE_NEG_PULSE) || (mode == `MODE_POS_PULSE);
	assign periodic = (mode == `MODE_NEG_PERIOD) || (mode == `MODE_POS_PERIOD);
	assign cycle_width = {cycle_width_b_reg, cycle_width_a_reg};

	// Start time comparison against the precision clock.
	assign now = {ptp_sec, ptp_ns};
	assign target = {tgt_sec_high_reg, tgt_sec_low_reg, tgt_ns_high_reg, tgt_ns_low_reg};
	assign lead_now = now + (`CASCADE_LEAD_CYC * `CLK_PERIOD_NS);
	assign reached = (now >= target);
	assign lead_reached = (lead_now >= target);
	assign past = (now > target);

	assign wr = psel && penable && access_reg && pwrite;
	assign sw_reset = wr && idx_hit(paddr, `IDX_SW_RESET) && |(pwdata[15:0] & unit_bit);
	assign enable_rise = unit_enable_reg && !enable_seen_reg;
	assign finite_end = (cycle_count_reg != 16'h0000) && (cyc_cnt_reg + 16'h0001 >= cycle_count_reg);

	// The edge select bit only exists for one unit; it trades mean frequency for fixed duty.
	width_accum u_accum (
		.pclk(pclk),
		.presetn(presetn),
		.clear(state_reg != S_RUN),
		.run(state_reg == S_RUN),
		.fixed_duty(edge_select_reg[`EDGE_SEL_BIT] && (UNIT_INDEX == EDGE_SEL_UNIT)),
		.width(cycle_width),
		.tick_reg(tick)
	);

	// APB setup phase: decode and latch read data so the access phase answers from flops.
	always @*
	begin
		rdata_next = 32'h00000000;
		unmapped_next = 1'b0;
		if (idx_hit(paddr, `IDX_ERROR_STATUS)) rdata_next[15:0] = error_reg ? unit_bit : 16'h0000;
		else if (idx_hit(paddr, `IDX_ACTIVE_STATUS))
			rdata_next[15:0] = (state_reg & (S_WAIT | S_RUN)) != 4'b0000 ? unit_bit : 16'h0000;
		else if (idx_hit(paddr, `IDX_DONE_STATUS)) rdata_next[15:0] = done_reg ? unit_bit : 16'h0000;
		else if (idx_hit(paddr, `IDX_UNIT_ENABLE)) rdata_next[15:0] = unit_enable_reg ? unit_bit : 16'h0000;
		else if (idx_hit(paddr, `IDX_SW_RESET)) rdata_next = 32'h00000000;
		else if (idx_hit(paddr, `IDX_IRQ_ENABLE)) rdata_next[15:0] = irq_enable_reg ? unit_bit : 16'h0000;
		else if (idx_hit(paddr, `IDX_TGT_NS_LOW)) rdata_next[15:0] = tgt_ns_low_reg;
		else if (idx_hit(paddr, `IDX_TGT_NS_HIGH)) rdata_next[15:0] = tgt_ns_high_reg;
		else if (idx_hit(paddr, `IDX_TGT_SEC_LOW)) rdata_next[15:0] = tgt_sec_low_reg;
		else if (idx_hit(paddr, `IDX_TGT_SEC_HIGH)) rdata_next[15:0] = tgt_sec_high_reg;
		else if (idx_hit(paddr, `IDX_MODE_PIN_CFG)) rdata_next[15:0] = mode_pin_config_reg;
		else if (idx_hit(paddr, `IDX_PULSE_WIDTH)) rdata_next[15:0] = pulse_width_reg;
		else if (idx_hit(paddr, `IDX_CYCLE_WIDTH_A)) rdata_next[15:0] = cycle_width_a_reg;
		else if (idx_hit(paddr, `IDX_CYCLE_WIDTH_B)) rdata_next[15:0] = cycle_width_b_reg;
		else if (idx_hit(paddr, `IDX_CYCLE_COUNT)) rdata_next[15:0] = cycle_count_reg;
		else if (idx_hit(paddr, `IDX_SHIFT_PATTERN)) rdata_next[15:0] = shift_pattern_reg;
		else if (idx_hit(paddr, `IDX_CLK_EDGE_SEL)) rdata_next[15:0] = edge_select_reg;
		else unmapped_next = 1'b1;
	end

	// Bus handshake: one access phase, pready high with no wait state.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			access_reg <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			access_reg <= psel && !penable;
			pready <= psel && !penable;
			pslverr <= psel && !penable && unmapped_next;
			if (psel && !penable && !pwrite)
				prdata <= rdata_next;
			else
				prdata <= 32'h00000000;
		end
	end

	// Configuration registers written by software; start-now is consumed by hardware.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tgt_ns_low_reg <= `RST_16;
			tgt_ns_high_reg <= `RST_16;
			tgt_sec_low_reg <= `RST_16;
			tgt_sec_high_reg <= `RST_16;
			mode_pin_config_reg <= `RST_16;
			pulse_width_reg <= `RST_16;
			cycle_width_a_reg <= `RST_16;
			cycle_width_b_reg <= `RST_16;
			cycle_count_reg <= `RST_16;
			shift_pattern_reg <= `RST_16;
			edge_select_reg <= `RST_16;
			unit_enable_reg <= 1'b0;
			irq_enable_reg <= 1'b0;
		end
		else
		begin
			if ((state_reg == S_WAIT) && start_now)
				mode_pin_config_reg[`CFG_START_NOW_BIT] <= 1'b0;
			if (sw_reset)
				unit_enable_reg <= 1'b0;
			if (wr)
			begin
				if (idx_hit(paddr, `IDX_TGT_NS_LOW)) tgt_ns_low_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_TGT_NS_HIGH)) tgt_ns_high_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_TGT_SEC_LOW)) tgt_sec_low_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_TGT_SEC_HIGH)) tgt_sec_high_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_MODE_PIN_CFG)) mode_pin_config_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_PULSE_WIDTH)) pulse_width_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_CYCLE_WIDTH_A)) cycle_width_a_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_CYCLE_WIDTH_B)) cycle_width_b_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_CYCLE_COUNT)) cycle_count_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_SHIFT_PATTERN)) shift_pattern_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_CLK_EDGE_SEL)) edge_select_reg <= pwdata[15:0];
				else if (idx_hit(paddr, `IDX_UNIT_ENABLE)) unit_enable_reg <= pwdata[UNIT_INDEX];
				else if (idx_hit(paddr, `IDX_IRQ_ENABLE)) irq_enable_reg <= pwdata[UNIT_INDEX];
			end
		end
	end

	// Sticky done and error: hardware set wins over a write-one clear in the same cycle.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_reg <= 1'b0;
			error_reg <= 1'b0;
			notify_irq <= 1'b0;
		end
		else
		begin
			if (state_reg == S_RUN && (state_next_halt))
				done_reg <= 1'b1;
			else if (wr && idx_hit(paddr, `IDX_DONE_STATUS) && pwdata[UNIT_INDEX])
				done_reg <= 1'b0;
			if (enable_rise && past && !start_now && state_reg == S_IDLE)
				error_reg <= 1'b1;
			else if (wr && idx_hit(paddr, `IDX_ERROR_STATUS) && pwdata[UNIT_INDEX])
				error_reg <= 1'b0;
			notify_irq <= (done_reg || error_reg) && mode_pin_config_reg[`CFG_NOTIFY_BIT] &&
				irq_enable_reg;
		end
	end

	// The run ends after one pulse, after the last counted cycle or shift, or at once for edges.
	always @*
	begin
		state_next_halt = 1'b0;
		if (mode == `MODE_NEG_EDGE || mode == `MODE_POS_EDGE)
			state_next_halt = 1'b1;
		else if (single_shot)
			state_next_halt = (hi_cnt_reg + 16'h0001 >= pulse_width_reg);
		else if (tick)
			state_next_halt = finite_end;
	end

	// Sequencer: idle, waiting for the target, running, halted until re-enabled.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= S_IDLE;
			enable_seen_reg <= 1'b0;
			level_reg <= 1'b0;
			drive_reg <= 1'b0;
			hi_cnt_reg <= 16'h0000;
			cyc_cnt_reg <= 16'h0000;
			shifter_reg <= 16'h0000;
		end
		else if (sw_reset || !unit_enable_reg)
		begin
			// Software reset drops the level so a later pin change cannot raise the new pin.
			state_reg <= S_IDLE;
			enable_seen_reg <= unit_enable_reg && !sw_reset;
			level_reg <= 1'b0;
			drive_reg <= 1'b0;
		end
		else
		begin
			enable_seen_reg <= 1'b1;
			case (state_reg)
				S_IDLE:
				begin
					if (enable_rise && past && !start_now)
						state_reg <= S_HALT;
					else if (enable_rise)
					begin
						state_reg <= S_WAIT;
						if (!cascade)
						begin
							level_reg <= !active_high;
							drive_reg <= 1'b1;
						end
					end
				end
				S_WAIT:
				begin
					if (cascade && lead_reached && !drive_reg)
					begin
						level_reg <= !active_high;
						drive_reg <= 1'b1;
					end
					if (reached || start_now)
					begin
						state_reg <= S_RUN;
						drive_reg <= 1'b1;
						hi_cnt_reg <= 16'h0000;
						cyc_cnt_reg <= 16'h0000;
						shifter_reg <= {shift_pattern_reg[14:0], shift_pattern_reg[15]};
						level_reg <= (mode == `MODE_PATTERN) ? shift_pattern_reg[15] : active_high;
					end
				end
				S_RUN:
				begin
					hi_cnt_reg <= hi_cnt_reg + 16'h0001;
					if (state_next_halt)
					begin
						state_reg <= S_HALT;
						if (mode != `MODE_NEG_EDGE && mode != `MODE_POS_EDGE)
							level_reg <= !active_high;
					end
					else if (periodic && tick)
					begin
						// New cycle; zero count never ends the run.
						cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
						hi_cnt_reg <= 16'h0000;
						level_reg <= active_high;
					end
					else if (periodic && (hi_cnt_reg + 16'h0001 >= pulse_width_reg))
						level_reg <= !active_high;
					else if ((mode == `MODE_PATTERN) && tick)
					begin
						cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
						level_reg <= shifter_reg[15];
						shifter_reg <= {shifter_reg[14:0], shifter_reg[15]};
					end
				end
				S_HALT:
					state_reg <= S_HALT;
				default:
					state_reg <= S_IDLE;
			endcase
		end
	end

	// Pin routing follows the live selection, so a rewrite moves a high level at once.
	always @*
	begin
		out_next = `RST_PIN_VEC;
		oe_next = `RST_PIN_VEC;
		if (drive_reg && pin < `PIN_COUNT)
		begin
			out_next[pin] = level_reg;
			oe_next[pin] = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gpio_out <= `RST_PIN_VEC;
			gpio_oe <= `RST_PIN_VEC;
		end
		else
		begin
			gpio_out <= out_next;
			gpio_oe <= oe_next;
		end
	end
endmodule // trigger_output_unit

// file: rtl/trigger_unit_map.vh
`ifndef TRIGGER_UNIT_MAP_VH
`define TRIGGER_UNIT_MAP_VH

// Register indices; the byte address on the APB bus is four times the index.
`define IDX_ERROR_STATUS 10'h200
`define IDX_ACTIVE_STATUS 10'h202
`define IDX_DONE_STATUS 10'h204
`define IDX_UNIT_ENABLE 10'h206
`define IDX_SW_RESET 10'h208
`define IDX_IRQ_ENABLE 10'h20c
`define IDX_TGT_NS_LOW 10'h210
`define IDX_TGT_NS_HIGH 10'h212
`define IDX_TGT_SEC_LOW 10'h214
`define IDX_TGT_SEC_HIGH 10'h216
`define IDX_MODE_PIN_CFG 10'h218
`define IDX_PULSE_WIDTH 10'h21a
`define IDX_CYCLE_WIDTH_A 10'h21c
`define IDX_CYCLE_WIDTH_B 10'h21e
`define IDX_CYCLE_COUNT 10'h220
`define IDX_SHIFT_PATTERN 10'h222
`define IDX_CLK_EDGE_SEL 10'h248

// Fields of the mode and pin configuration register; EDGE_SEL_BIT is in the edge select register.
`define CFG_PIN_MSB 3
`define CFG_PIN_LSB 0
`define CFG_MODE_MSB 6
`define CFG_MODE_LSB 4
`define CFG_NOTIFY_BIT 8
`define CFG_START_NOW_BIT 9
`define CFG_CASCADE_BIT 10
`define EDGE_SEL_BIT 7

// Waveform type codes.
`define MODE_NEG_EDGE 3'h0
`define MODE_POS_EDGE 3'h1
`define MODE_NEG_PULSE 3'h2
`define MODE_POS_PULSE 3'h3
`define MODE_NEG_PERIOD 3'h4
`define MODE_POS_PERIOD 3'h5
`define MODE_PATTERN 3'h6

// Reset values.
`define RST_16 16'h0000
`define RST_PIN_VEC 12'h000

// Timing: clock period and cascade lead time in ns, lead in cycles.
`define CLK_PERIOD_NS 8
`define CASCADE_LEAD_NS 8
`define CASCADE_LEAD_CYC ((`CASCADE_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_COUNT 12

`endif

// file: rtl/width_accum.v
`timescale 1ns/100ps
`include "trigger_unit_map.vh"

// Accumulates elapsed time in 1 ns units at one clock period per cycle and
// pulses tick_reg when a full cycle or bit width has passed.
module width_accum (
	input wire pclk,
	input wire presetn,
	input wire clear,
	input wire run,
	input wire fixed_duty,
	input wire [31:0] width,
	output reg tick_reg
);
	reg [32:0] acc_reg;
	wire [32:0] sum;

	assign sum = acc_reg + 33'd`CLK_PERIOD_NS;

	// Carrying the remainder keeps the mean frequency exact at the cost of
	// duty-cycle jitter; fixed duty restarts each cycle and rounds the period up.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_reg <= 33'h000000000;
			tick_reg <= 1'b0;
		end
		else if (clear)
		begin
			acc_reg <= 33'd`CLK_PERIOD_NS; // One period pre-loaded covers the cycle lost to the registered tick.
			tick_reg <= 1'b0;
		end
		else if (run && (sum >= {1'b0, width}))
		begin
			acc_reg <= fixed_duty ? 33'h000000000 : (sum - {1'b0, width});
			tick_reg <= 1'b1;
		end
		else
		begin
			acc_reg <= run ? sum : acc_reg;
			tick_reg <= 1'b0;
		end
	end
endmodule // width_accum

// file: testbench/test_trigger_output_unit.sv
`timescale 1ns/100ps
`include "trigger_unit_map.vh"
module test_trigger_output_unit;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [31:0] pwdata = 32'h00000000;
	reg [31:0] ptp_ns = 32'h00000000;
	reg [31:0] ptp_sec = 32'h00000000;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire [11:0] gpio_out;
	wire [11:0] gpio_oe;
	wire notify_irq;
	integer fails = 0;
	integer compares = 0;
	integer i;
	integer k;
	integer n;
	integer rises;
	integer highs;
	reg [31:0] rd;
	reg err;
	reg [31:0] tgt;
	trigger_output_unit trigger_output_unit_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ptp_sec(ptp_sec), .ptp_ns(ptp_ns), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .notify_irq(notify_irq));
	// Clock and a nanosecond time base that advances one period per cycle.
	always #4 pclk = ~pclk;
	always @(posedge pclk)
		ptp_ns <= ptp_ns + 32'd8;
	task conclude;
	begin
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task check(input [31:0] got, input [31:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
			fails = fails + 1;
		end
	end
	endtask
	// One APB transfer; the request stands until pready is sampled high.
	task apb(input w, input [9:0] idx, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20)
		begin
			@(posedge pclk);
			k = k + 1;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20)
		begin
			fails = fails + 1;
			conclude;
		end
	end
	endtask
	task wr(input [9:0] idx, input [31:0] d);
		apb(1'b1, idx, d);
	endtask
	task rdc(input [9:0] idx, input [31:0] exp);
	begin
		apb(1'b0, idx, 32'h0);
		check(rd, exp);
	end
	endtask
	// Waits for a pin level; n ends as the number of further edges it took.
	task wait_level(input [3:0] pin, input lvl);
	begin
		n = 0;
		@(posedge pclk);
		while (gpio_out[pin] !== lvl && n < 2000)
		begin
			@(posedge pclk);
			n = n + 1;
		end
		if (n >= 2000)
		begin
			fails = fails + 1;
			conclude;
		end
	end
	endtask
	task watch(input [3:0] pin, input integer cyc);
		reg last;
	begin
		last = gpio_out[pin];
		rises = 0;
		highs = 0;
		repeat (cyc)
		begin
			@(posedge pclk);
			if (gpio_out[pin] === 1'b1)
				highs = highs + 1;
			if (gpio_out[pin] === 1'b1 && last === 1'b0)
				rises = rises + 1;
			last = gpio_out[pin];
		end
	end
	endtask
	// Software reset first so leftovers of a previous run never reach the pin.
	task setup(input [15:0] cfg, input [15:0] pw, input [15:0] cw, input [15:0] cnt, input [31:0] t, input en);
	begin
		wr(`IDX_SW_RESET, 32'h1);
		wr(`IDX_DONE_STATUS, 32'h1);
		wr(`IDX_ERROR_STATUS, 32'h1);
		wr(`IDX_TGT_NS_LOW, {16'h0, t[15:0]});
		wr(`IDX_TGT_NS_HIGH, {16'h0, t[31:16]});
		wr(`IDX_TGT_SEC_LOW, 32'h0);
		wr(`IDX_TGT_SEC_HIGH, 32'h0);
		wr(`IDX_PULSE_WIDTH, {16'h0, pw});
		wr(`IDX_CYCLE_WIDTH_A, {16'h0, cw});
		wr(`IDX_CYCLE_WIDTH_B, 32'h0);
		wr(`IDX_CYCLE_COUNT, {16'h0, cnt});
		wr(`IDX_MODE_PIN_CFG, {16'h0, cfg});
		wr(`IDX_UNIT_ENABLE, {31'h0, en});
	end
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, read-back of the 16-bit fields except the mode register, and a refused address.
		for (i = 'h200; i <= 'h222; i = i + 2)
			rdc(i[9:0], 32'h0);
		for (i = 'h210; i <= 'h222; i = i + 2)
		begin
			if (i != 'h218)
				wr(i[9:0], 32'hffffa5c3);
			if (i != 'h218)
				rdc(i[9:0], 32'h0000a5c3);
		end
		wr(`IDX_CLK_EDGE_SEL, 32'h80);
		rdc(`IDX_CLK_EDGE_SEL, 32'h80);
		wr(10'h20e, 32'h1234);
		rdc(10'h20e, 32'h0);
		check({31'h0, err}, 32'h1);
		wr(`IDX_IRQ_ENABLE, 32'h1);
		// High-going pulse on pin 3 with notify, five steps wide.
		tgt = ptp_ns + 32'd800;
		setup(16'h0133, 16'd5, 16'd0, 16'd0, tgt, 1'b1);
		repeat (4) @(posedge pclk);
		check({20'h0, gpio_oe}, 32'h008);
		check({20'h0, gpio_out}, 32'h000);
		wait_level(4'd3, 1'b1);
		check({31'h0, ptp_ns >= tgt}, 32'h1);
		check({31'h0, ptp_ns <= tgt + 32'd40}, 32'h1);
		wait_level(4'd3, 1'b0);
		check(n, 5 - 1);
		repeat (4) @(posedge pclk);
		rdc(`IDX_DONE_STATUS, 32'h1);
		check({31'h0, notify_irq}, 32'h1);
		// Low-going pulse on pin 5 without notify: idle high, no interrupt.
		setup(16'h0025, 16'd3, 16'd0, 16'd0, ptp_ns + 32'd800, 1'b1);
		repeat (4) @(posedge pclk);
		check({20'h0, gpio_out}, 32'h020);
		wait_level(4'd5, 1'b0);
		wait_level(4'd5, 1'b1);
		check(n, 3 - 1);
		repeat (4) @(posedge pclk);
		check({31'h0, notify_irq}, 32'h0);
		// A target already past, here by a whole second, gives an error and no output.
		ptp_sec <= 32'h00000001;
		setup(16'h0131, 16'd1, 16'd0, 16'd0, 32'hfff00000, 1'b1);
		repeat (6) @(posedge pclk);
		rdc(`IDX_ERROR_STATUS, 32'h1);
		check({20'h0, gpio_out}, 32'h000);
		check({31'h0, notify_irq}, 32'h1);
		ptp_sec <= 32'h00000000;
		// Start-now while disabled must not drive the pin.
		setup(16'h0232, 16'd4, 16'd0, 16'd0, 32'hfff00000, 1'b0);
		repeat (8) @(posedge pclk);
		check({20'h0, gpio_oe}, 32'h000);
		// Three periods of 48 ns, 16 ns high, started at once.
		setup(16'h0152, 16'd2, 16'd48, 16'd3, 32'hfff00000, 1'b1);
		wr(`IDX_MODE_PIN_CFG, 32'h0352);
		watch(4'd2, 80);
		check(rises, 3);
		check(highs, 3 * 2);
		rdc(`IDX_DONE_STATUS, 32'h1);
		// Zero count keeps running.
		setup(16'h0152, 16'd1, 16'd32, 16'd0, 32'hfff00000, 1'b1);
		wr(`IDX_MODE_PIN_CFG, 32'h0352);
		watch(4'd2, 80);
		check({31'h0, rises > 15}, 32'h1);
		// Eight pattern bits, MSB first, 16 ns each: 1010 0101.
		setup(16'h0164, 16'd0, 16'd16, 16'd8, 32'hfff00000, 1'b1);
		wr(`IDX_SHIFT_PATTERN, 32'h0000a5c3);
		wr(`IDX_MODE_PIN_CFG, 32'h0364);
		watch(4'd4, 60);
		check(rises, 4);
		check(highs, 4 * 2);
		// Cascaded low-going pulse on pin 2: undriven at enable, high for one cycle before the pulse.
		tgt = ptp_ns + 32'd800;
		setup(16'h0422, 16'd1, 16'd0, 16'd0, tgt, 1'b1);
		repeat (4) @(posedge pclk);
		check({20'h0, gpio_oe}, 32'h000);
		wait_level(4'd2, 1'b1);
		check(ptp_ns, tgt + 32'd8);
		wait_level(4'd2, 1'b0);
		check(n, 0);
		// A held high level follows a pin change unless reset first.
		setup(16'h0011, 16'd0, 16'd0, 16'd0, 32'hfff00000, 1'b1);
		wr(`IDX_MODE_PIN_CFG, 32'h0211);
		repeat (6) @(posedge pclk);
		check({20'h0, gpio_out}, 32'h002);
		wr(`IDX_MODE_PIN_CFG, 32'h0015);
		repeat (4) @(posedge pclk);
		check({20'h0, gpio_out}, 32'h020);
		wr(`IDX_SW_RESET, 32'h1);
		wr(`IDX_MODE_PIN_CFG, 32'h0017);
		repeat (4) @(posedge pclk);
		check({20'h0, gpio_out}, 32'h000);
		conclude;
	end
endmodule // test_trigger_output_unit

// file: testbench/trigger_output_unit_monitor.sv
`timescale 1ns/100ps
`include "trigger_unit_map.vh"
module trigger_output_unit_monitor #(
	parameter UNIT_INDEX = 0
) (
	input wire pclk,
	input wire presetn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [31:0] ptp_sec,
	input wire [31:0] ptp_ns,
	input wire [11:0] gpio_out,
	input wire [11:0] gpio_oe,
	input wire notify_irq
);
	reg ie_reg;
	reg nb_reg;
	wire wr_done = psel && penable && pready && pwrite;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Shadow the enable and notify bits from completed writes, so the interrupt is judged from the ports alone.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ie_reg <= 1'b0;
			nb_reg <= 1'b0;
		end
		else if (wr_done && paddr[11:2] == `IDX_IRQ_ENABLE)
			ie_reg <= pwdata[UNIT_INDEX];
		else if (wr_done && paddr[11:2] == `IDX_MODE_PIN_CFG)
			nb_reg <= pwdata[`CFG_NOTIFY_BIT];
	end
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data outside access");
	a_rdata_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_pin_single_high: assert property ($onehot0(gpio_out))
		else $error("more than one pin high");
	a_pin_driven_high: assert property ((gpio_out & ~gpio_oe) == 12'h000)
		else $error("high level on undriven pin");
	a_enable_single_pin: assert property ($onehot0(gpio_oe))
		else $error("more than one pin driven");
	a_irq_needs_bits: assert property (notify_irq |-> (ie_reg || $past(ie_reg)) && (nb_reg || $past(nb_reg)))
		else $error("interrupt without enable and notify");
	c_irq: cover property (notify_irq);
	c_refused: cover property (pslverr);
	c_pin_rise: cover property ($rose(gpio_out[3]));
endmodule // trigger_output_unit_monitor

bind trigger_output_unit trigger_output_unit_monitor #(.UNIT_INDEX(UNIT_INDEX)) trigger_output_unit_monitor_i (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ptp_sec(ptp_sec),
	.ptp_ns(ptp_ns), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .notify_irq(notify_irq));
